/* core/epc_pkg.sv */
/*
 * Constants, register map and carrier types for the extended
 * power-condition subcommand handler.
 * Assumes a single 100 MHz clock domain and an APB register bus.
 */
package epc_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCOND = 4;
    localparam int COND_IDX_W = 2;

    // ****************************************
    // Command and subcommand codes
    // ****************************************
    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
    localparam logic [7:0] FEAT_EPC = 8'h4A;
    localparam logic [3:0] SUB_RESTORE = 4'h0;
    localparam logic [3:0] SUB_GOTO = 4'h1;
    localparam logic [3:0] SUB_SET_TIMER = 4'h2;
    localparam logic [7:0] ID_ALL = 8'hFF;
    // Power condition identifiers, entry i holds byte i
    localparam logic [NCOND*8-1:0] COND_IDS = 32'h03020100;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SN_UNITS_BIT = 7;
    localparam int SN_DEFAULT_BIT = 6;
    localparam int SN_ENABLE_BIT = 5;
    localparam int SN_SAVE_BIT = 4;
    localparam int ERR_ABORT_BIT = 2;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_READY_BIT = 6;
    localparam int ST_ERR_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_TASKFILE = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_ERROR = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_POWER = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_COND_SEL = 8'h24;
    localparam logic [7:0] OFS_COND_CUR = 8'h28;
    localparam logic [7:0] OFS_COND_SAVED = 8'h2C;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] ERR_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h40;
    localparam logic CFG_EPC_EN_RST = 1'b1;
    localparam logic [NCOND-1:0] CFG_MASK_RST = 4'hF;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} fsm_e;

    typedef struct packed {
        logic units;
        logic [15:0] value;
    } tmr_s;

    typedef struct packed {
        logic en;
        tmr_s tmr;
    } setting_s;

    typedef struct packed {
        logic load_cur;
        setting_s cur;
        logic save_tmr;
        logic save_en;
    } entry_ctl_s;

    localparam setting_s COND_DEFAULT = '{en: 1'b1, tmr: '{units: 1'b0, value: 16'h0064}};

    typedef struct packed {
        fsm_e fsm;
        logic [7:0] feature;
        logic [7:0] sec_count;
        logic [7:0] sec_num;
        logic [15:0] cyl;
        logic [7:0] err;
        logic [7:0] status;
        logic epc_en;
        logic [NCOND-1:0] supp;
        logic [NCOND-1:0] chg;
        logic [NCOND-1:0] sav;
        logic forced;
        logic [7:0] forced_id;
        logic stopped;
        logic [NCOND-1:0] timer_run;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic [COND_IDX_W-1:0] cond_idx;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } core_s;

endpackage

/* core/epc_cond_entry.sv */
/*
 * One power-condition settings entry: current and saved timer
 * settings, default settings fixed by parameter.
 * Assumes the controller only raises the load and save strobes for a
 * command that was not aborted.
 */
`timescale 1ns/1ns
module epc_cond_entry
    import epc_pkg::*;
#(
    parameter setting_s DEFAULT = COND_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire entry_ctl_s ctl,
    output setting_s cur_o,
    output setting_s saved_o,
    output setting_s default_o
);

    typedef struct packed {
        setting_s cur;
        setting_s saved;
    } entry_s;

    entry_s st_r;
    entry_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ctl.load_cur) begin
            st_nxt.cur = ctl.cur;
        end
        if (ctl.save_tmr) begin
            st_nxt.saved.tmr = ctl.cur.tmr;
        end
        if (ctl.save_en) begin
            st_nxt.saved.en = ctl.cur.en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{cur: DEFAULT, saved: DEFAULT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cur_o = st_r.cur;
    assign saved_o = st_r.saved;
    assign default_o = DEFAULT;

endmodule

/* core/epc_subcommand_handler.sv */
/*
 * Extended power-condition subcommand handler: task-file registers,
 * command execution, per-condition settings and interrupt, over APB.
 * Assumes an APB master on pclk; commands start by writing the
 * command register after the task-file and timer registers are set.
 */
`timescale 1ns/1ns

module epc_subcommand_handler
    import epc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic forced_cond_valid,
    output logic [7:0] forced_cond_id,
    output logic [NCOND-1:0] timer_run
);

    // ****************************************
    // State and entry wiring
    // ****************************************
    core_s st_r;
    core_s st_nxt;
    entry_ctl_s ctl [NCOND];
    setting_s cur_set [NCOND];
    setting_s saved_set [NCOND];
    setting_s dflt_set [NCOND];

    logic access;
    logic wr_go;
    logic [NCOND-1:0] sel;
    logic [NCOND-1:0] cur_en;
    logic abort;
    logic save_flag;
    logic [1:0] irq_set;
    setting_s new_set;
    setting_s rd_cur;
    setting_s rd_saved;

    genvar gi;
    generate
        for (gi = 0; gi < NCOND; gi++) begin : g_entry
            epc_cond_entry #(
                .DEFAULT(COND_DEFAULT)
            ) u_entry (
                .pclk(pclk),
                .presetn(presetn),
                .ctl(ctl[gi]),
                .cur_o(cur_set[gi]),
                .saved_o(saved_set[gi]),
                .default_o(dflt_set[gi])
            );
            assign cur_en[gi] = cur_set[gi].en;
        end
    endgenerate

    assign rd_cur = cur_set[st_r.cond_idx];
    assign rd_saved = saved_set[st_r.cond_idx];

    // ****************************************
    // Identifier decode
    // ****************************************
    // One-hot over entries; all ones for the all-conditions identifier
    function automatic logic [NCOND-1:0] id_decode(input logic [7:0] id);
        logic [NCOND-1:0] hit;
        hit = '0;
        for (int i = 0; i < NCOND; i++) begin
            hit[i] = (id == COND_IDS[i*8 +: 8]) || (id == ID_ALL);
        end
        return hit;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        abort = 1'b0;
        irq_set = '0;
        save_flag = st_r.sec_num[SN_SAVE_BIT];
        sel = id_decode(st_r.sec_count);
        new_set = '0;
        for (int i = 0; i < NCOND; i++) begin
            ctl[i] = '0;
        end

        // APB: one wait state; write lands on the edge that samples pready
        access = psel && penable && !st_r.pready;
        wr_go = psel && penable && pwrite && st_r.pready;
        st_nxt.pready = access;
        st_nxt.pslverr = 1'b0;

        if (access) begin
            st_nxt.prdata = '0;
            if (paddr == OFS_TASKFILE) begin
                st_nxt.prdata = {8'h00, st_r.sec_num, st_r.sec_count, st_r.feature};
            end else if (paddr == OFS_TIMER) begin
                st_nxt.prdata = {16'h0000, st_r.cyl};
            end else if (paddr == OFS_COMMAND) begin
                st_nxt.prdata = '0;
            end else if (paddr == OFS_ERROR) begin
                st_nxt.prdata = {24'h000000, st_r.err};
            end else if (paddr == OFS_STATUS) begin
                st_nxt.prdata = {24'h000000, st_r.status};
            end else if (paddr == OFS_CONFIG) begin
                st_nxt.prdata = {16'h0000, st_r.sav, st_r.chg, st_r.supp, 3'h0, st_r.epc_en};
            end else if (paddr == OFS_POWER) begin
                st_nxt.prdata = {8'h00, st_r.forced_id, st_r.forced, 10'h000, st_r.stopped,
                    st_r.timer_run};
            end else if (paddr == OFS_IRQ_STAT) begin
                st_nxt.prdata = {30'h00000000, st_r.irq_stat};
            end else if (paddr == OFS_IRQ_MASK) begin
                st_nxt.prdata = {30'h00000000, st_r.irq_mask};
            end else if (paddr == OFS_COND_SEL) begin
                st_nxt.prdata = {30'h00000000, st_r.cond_idx};
            end else if (paddr == OFS_COND_CUR) begin
                st_nxt.prdata = {14'h0000, rd_cur};
            end else if (paddr == OFS_COND_SAVED) begin
                st_nxt.prdata = {14'h0000, rd_saved};
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end

        if (wr_go) begin
            if (paddr == OFS_TASKFILE) begin
                st_nxt.feature = pwdata[7:0];
                st_nxt.sec_count = pwdata[15:8];
                st_nxt.sec_num = pwdata[23:16];
            end else if (paddr == OFS_TIMER) begin
                st_nxt.cyl = pwdata[15:0];
            end else if (paddr == OFS_COMMAND) begin
                // A command written while one executes is dropped
                if (st_r.fsm == ST_IDLE) begin
                    st_nxt.fsm = ST_EXEC;
                    st_nxt.status[ST_BUSY_BIT] = 1'b1;
                    st_nxt.status[ST_READY_BIT] = 1'b0;
                    st_nxt.status[ST_ERR_BIT] = 1'b0;
                    st_nxt.err = ERR_RST;
                    st_nxt.forced = 1'b0;
                    st_nxt.stopped = 1'b0;
                    st_nxt.feature = (pwdata[7:0] == CMD_SET_FEATURES) ? st_r.feature : 8'h00;
                end
            end else if (paddr == OFS_CONFIG) begin
                st_nxt.epc_en = pwdata[0];
                st_nxt.supp = pwdata[7:4];
                st_nxt.chg = pwdata[11:8];
                st_nxt.sav = pwdata[15:12];
            end else if (paddr == OFS_IRQ_STAT) begin
                st_nxt.irq_stat = st_r.irq_stat & ~pwdata[1:0];
            end else if (paddr == OFS_IRQ_MASK) begin
                st_nxt.irq_mask = pwdata[1:0];
            end else if (paddr == OFS_COND_SEL) begin
                st_nxt.cond_idx = pwdata[COND_IDX_W-1:0];
            end
        end

        // ****************************************
        // Command execution
        // ****************************************
        if (st_r.fsm == ST_EXEC) begin
            st_nxt.fsm = ST_IDLE;
            if (st_r.feature != FEAT_EPC) begin
                abort = 1'b1;
            end else begin
                case (st_r.sec_num[3:0])
                    SUB_RESTORE: begin
                        abort = !st_r.epc_en || (sel == '0) || ((sel & ~st_r.supp) != '0)
                            || ((sel & ~st_r.chg) != '0)
                            || (save_flag && ((sel & ~st_r.sav) != '0));
                        for (int i = 0; i < NCOND; i++) begin
                            ctl[i].load_cur = sel[i];
                            if (st_r.sec_num[SN_DEFAULT_BIT]) begin
                                ctl[i].cur = dflt_set[i];
                            end else begin
                                ctl[i].cur = saved_set[i];
                            end
                            ctl[i].save_tmr = sel[i] && save_flag && st_r.sav[i];
                        end
                    end
                    SUB_GOTO: begin
                        abort = !st_r.epc_en || (st_r.sec_count == ID_ALL) || (sel == '0)
                            || ((sel & ~st_r.supp) != '0);
                        if (!abort) begin
                            st_nxt.stopped = 1'b1;
                            st_nxt.forced = 1'b1;
                            st_nxt.forced_id = st_r.sec_count;
                        end
                    end
                    SUB_SET_TIMER: begin
                        abort = !st_r.epc_en || (sel == '0) || ((sel & ~st_r.supp) != '0)
                            || ((sel & ~st_r.chg) != '0)
                            || (save_flag && ((sel & ~st_r.sav) != '0));
                        new_set.tmr.units = st_r.sec_num[SN_UNITS_BIT];
                        new_set.tmr.value = st_r.cyl;
                        new_set.en = st_r.sec_num[SN_ENABLE_BIT] && (st_r.cyl != 16'h0000);
                        for (int i = 0; i < NCOND; i++) begin
                            ctl[i].load_cur = sel[i];
                            ctl[i].cur = new_set;
                            ctl[i].save_tmr = sel[i] && save_flag && st_r.sav[i];
                            ctl[i].save_en = sel[i] && save_flag && st_r.sav[i];
                        end
                    end
                    default: begin
                        abort = 1'b1;
                    end
                endcase
            end
            // Aborted commands leave every entry as it was
            for (int i = 0; i < NCOND; i++) begin
                if (abort) begin
                    ctl[i] = '0;
                end
            end
            st_nxt.err[ERR_ABORT_BIT] = abort;
            st_nxt.status[ST_ERR_BIT] = abort;
            st_nxt.status[ST_BUSY_BIT] = 1'b0;
            st_nxt.status[ST_READY_BIT] = 1'b1;
            irq_set[IRQ_DONE_BIT] = 1'b1;
            irq_set[IRQ_ABORT_BIT] = abort;
        end

        // Set after clear so an event in the clearing cycle survives
        st_nxt.irq_stat = st_nxt.irq_stat | irq_set;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
        // Running view lags the entries by one cycle
        st_nxt.timer_run = st_nxt.stopped ? '0 : cur_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.fsm <= ST_IDLE;
            st_r.err <= ERR_RST;
            st_r.status <= STATUS_RST;
            st_r.epc_en <= CFG_EPC_EN_RST;
            st_r.supp <= CFG_MASK_RST;
            st_r.chg <= CFG_MASK_RST;
            st_r.sav <= CFG_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq = st_r.irq;
    assign forced_cond_valid = st_r.forced;
    assign forced_cond_id = st_r.forced_id;
    assign timer_run = st_r.timer_run;

endmodule

/* tb/epc_subcommand_handler_monitor.sv */
/* Port checker bound to the subcommand handler top.
   Assumes one pclk domain and an APB master that holds its requests. */
`timescale 1ns/1ns
module epc_subcommand_handler_monitor
    import epc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic forced_cond_valid,
    input wire logic [7:0] forced_cond_id,
    input wire logic [NCOND-1:0] timer_run
);
    // ******
    // Checks
    // ******
    logic cmd_wr;
    logic mapped;
    logic [2:0] since_cmd_r;
    assign cmd_wr = psel && penable && pready && pwrite && paddr == OFS_COMMAND;
    assign mapped = paddr <= OFS_COND_SAVED && paddr[1:0] == 2'h0;
    // Saturates, so an old command never excuses a late change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_cmd_r <= 3'h7;
        else if (cmd_wr) since_cmd_r <= 3'h0;
        else if (since_cmd_r != 3'h7) since_cmd_r <= since_cmd_r + 3'h1;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("pslverr missing");
    a_err_mapped: assert property (pslverr |-> pready && !mapped)
        else $error("pslverr spurious");
    a_forced_start: assert property ($rose(forced_cond_valid) |-> since_cmd_r < 3'h5)
        else $error("forced without command");
    a_forced_hold: assert property ($fell(forced_cond_valid) |-> since_cmd_r < 3'h5)
        else $error("forced dropped without command");
    a_forced_min: assert property ($rose(forced_cond_valid) |=> forced_cond_valid [*3])
        else $error("forced dropped early");
    a_forced_stop: assert property (forced_cond_valid && since_cmd_r > 3'h4
        |-> timer_run == '0) else $error("timer running while forced");
    a_forced_id: assert property (forced_cond_valid && $past(forced_cond_valid)
        |-> $stable(forced_cond_id)) else $error("forced id changed");
    c_forced: cover property ($rose(forced_cond_valid));
    c_slverr: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind epc_subcommand_handler epc_subcommand_handler_monitor u_mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .forced_cond_valid(forced_cond_valid), .forced_cond_id(forced_cond_id),
    .timer_run(timer_run));

/* tb/epc_host.sv */
/* Host controller model: APB master issuing task-file commands.
   Assumes pclk from the bench; waits for pready with a bound. */
`timescale 1ns/1ns
module epc_host
    import epc_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // *********
    // Bus cycle
    // *********
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err, output logic to);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        to = pready !== 1'b1;
        rd = prdata;
        err = pslverr;
        // Released lines show no stale value; idle edge avoids double drive
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
    task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] id,
            input logic [7:0] sn, input logic [15:0] t, output logic to);
        logic [31:0] rd;
        logic e;
        logic t1;
        logic t2;
        xfer(1'b1, OFS_TASKFILE, {8'h00, sn, id, f}, rd, e, t1);
        xfer(1'b1, OFS_TIMER, {16'h0000, t}, rd, e, t2);
        xfer(1'b1, OFS_COMMAND, {24'h000000, c}, rd, e, to);
        to = to | t1 | t2;
    endtask
endmodule

/* tb/epc_subcommand_handler_tb.sv */
/* Self-checking bench: the host model issues random subcommands and a
   reference model predicts registers and ports. Monitor is bound. */
`timescale 1ns/1ns
module epc_subcommand_handler_tb
    import epc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, forced_cond_valid;
    logic [7:0] paddr, forced_cond_id;
    logic [31:0] pwdata, prdata;
    logic [NCOND-1:0] timer_run, supp_m, chg_m, svb_m;
    int err_total, checks;
    setting_s cur_m[NCOND], sav_m[NCOND];
    logic en_m, frc_m;
    logic [7:0] fid_m;
    logic [1:0] msk_m;
    epc_subcommand_handler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .forced_cond_valid(forced_cond_valid), .forced_cond_id(forced_cond_id),
        .timer_run(timer_run));
    epc_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // *****
    // Tasks
    // *****
    task automatic finish_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
        logic to;
        u_host.xfer(w, a, d, rd, er, to);
        if (to) begin
            err_total++;
            finish_test();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] rd;
        logic er;
        bus(1'b0, a, 32'h0, rd, er);
        cmp(nm, e, rd);
    endtask
    task automatic mdl_rst();
        for (int k = 0; k < NCOND; k++) begin
            cur_m[k] = COND_DEFAULT;
            sav_m[k] = COND_DEFAULT;
        end
        {svb_m, chg_m, supp_m} = {3{CFG_MASK_RST}};
        en_m = CFG_EPC_EN_RST;
        frc_m = 1'b0;
        fid_m = 8'h00;
        msk_m = 2'h0;
    endtask
    task automatic chk_all();
        logic [31:0] rd;
        logic er;
        logic [NCOND-1:0] tr;
        for (int i = 0; i < NCOND; i++) begin
            tr[i] = cur_m[i].en && !frc_m;
            bus(1'b1, OFS_COND_SEL, 32'(i), rd, er);
            rdc(OFS_COND_CUR, {14'h0000, cur_m[i]}, "cur");
            rdc(OFS_COND_SAVED, {14'h0000, sav_m[i]}, "saved");
        end
        bus(1'b0, OFS_POWER, 32'h0, rd, er);
        cmp("power", {8'h00, fid_m, frc_m, 10'h000, frc_m, tr}, rd);
        cmp("timer_run", tr, timer_run);
        cmp("forced", frc_m, forced_cond_valid);
        cmp("forced_id", fid_m, forced_cond_id);
    endtask
    task automatic run_cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] id,
            input logic [7:0] sn, input logic [15:0] t);
        logic ab;
        logic to;
        logic er;
        logic [NCOND-1:0] s;
        logic [31:0] rd;
        int n;
        s = id == ID_ALL ? {NCOND{1'b1}} : id < NCOND ? NCOND'(1) << id : '0;
        ab = c != CMD_SET_FEATURES || f != FEAT_EPC || !en_m || s == '0;
        ab = ab || sn[3:0] > SUB_SET_TIMER;
        if (sn[3:0] == SUB_GOTO) begin
            ab = ab || id == ID_ALL || (s & ~supp_m) != '0;
        end else begin
            ab = ab || (s & ~(supp_m & chg_m)) != '0;
            ab = ab || sn[SN_SAVE_BIT] && (s & ~svb_m) != '0;
        end
        frc_m = 1'b0;
        for (int i = 0; i < NCOND; i++) begin
            if (!ab && s[i]) begin
                case (sn[3:0])
                    SUB_RESTORE: begin
                        cur_m[i] = sn[SN_DEFAULT_BIT] ? COND_DEFAULT : sav_m[i];
                        if (sn[SN_SAVE_BIT]) sav_m[i].tmr = cur_m[i].tmr;
                    end
                    SUB_GOTO: begin
                        frc_m = 1'b1;
                        fid_m = id;
                    end
                    default: begin
                        cur_m[i].tmr = {sn[SN_UNITS_BIT], t};
                        cur_m[i].en = sn[SN_ENABLE_BIT] && t != 16'h0000;
                        if (sn[SN_SAVE_BIT]) sav_m[i] = cur_m[i];
                    end
                endcase
            end
        end
        u_host.issue(c, f, id, sn, t, to);
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, rd, er);
            n++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 8);
        if (to || rd[ST_BUSY_BIT] !== 1'b0) begin
            err_total++;
            finish_test();
        end
        cmp("status", {24'h0, ab ? 8'h41 : 8'h40}, rd);
        rdc(OFS_ERROR, {29'h0, ab, 2'h0}, "error");
        bus(1'b0, OFS_IRQ_STAT, 32'h0, rd, er);
        cmp("irq_stat", {ab, 1'b1}, rd);
        cmp("irq", |({ab, 1'b1} & msk_m), irq);
        bus(1'b1, OFS_IRQ_STAT, 32'h3, rd, er);
        @(posedge pclk);
        cmp("irq_clr", 1'b0, irq);
        chk_all();
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        logic [31:0] rd;
        logic er;
        logic [7:0] id;
        presetn = 1'b0;
        err_total = 0;
        checks = 0;
        mdl_rst();
        void'($urandom(49160));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(OFS_STATUS, {24'h0, STATUS_RST}, "status_rst");
        rdc(OFS_ERROR, {24'h0, ERR_RST}, "error_rst");
        rdc(OFS_CONFIG, {16'h0, {3{CFG_MASK_RST}}, 3'h0, CFG_EPC_EN_RST}, "config_rst");
        rdc(OFS_IRQ_MASK, 32'h0, "mask_rst");
        bus(1'b1, OFS_STATUS, 32'hFFFFFFFF, rd, er);
        rdc(OFS_STATUS, {24'h0, STATUS_RST}, "status_ro");
        bus(1'b0, 8'h30, 32'h0, rd, er);
        cmp("slverr", 1'b1, er);
        chk_all();
        for (int k = 0; k < 90; k++) begin
            if (k == 45) begin
                presetn <= 1'b0;
                repeat (2) @(posedge pclk);
                presetn <= 1'b1;
                mdl_rst();
                @(posedge pclk);
                chk_all();
            end
            if (k % 10 == 9) begin
                rd = $urandom & 32'hFFF1;
                rd[0] = $urandom_range(0, 3) != 0;
                if (k % 20 == 19) rd = 32'hFFF1;
                {svb_m, chg_m, supp_m} = rd[15:4];
                en_m = rd[0];
                bus(1'b1, OFS_CONFIG, rd, rd, er);
            end
            msk_m = 2'($urandom);
            bus(1'b1, OFS_IRQ_MASK, {30'h0, msk_m}, rd, er);
            id = 8'($urandom_range(0, 5));
            id = id < 4 ? id : id == 4 ? ID_ALL : 8'($urandom);
            rd = $urandom;
            run_cmd(rd[31:29] == 0 ? 8'($urandom) : CMD_SET_FEATURES,
                rd[28:26] == 0 ? 8'($urandom) : FEAT_EPC, id,
                {rd[7:4], 4'(k % 5)}, rd[25] ? 16'h0000 : rd[23:8]);
        end
        finish_test();
    end
endmodule
